// [logic/pbw_consts.svh]
`ifndef PBW_CONSTS_SVH
`define PBW_CONSTS_SVH

// clock rate and derived cycle counts
`define PBW_CLK_HZ          50000000
`define PBW_MIN_PULSE_US    1000
`define PBW_HOLD_MS         1000
`define PBW_REPEAT_MS       100
`define PBW_IDLE_REV_MS     1000
`define PBW_STORE_MS        2000
`define PBW_DSTEP_MIN_US    1
`define PBW_MIN_PULSE_CYC   ((`PBW_CLK_HZ / 1000000) * `PBW_MIN_PULSE_US)
`define PBW_HOLD_CYC        ((`PBW_CLK_HZ / 1000) * `PBW_HOLD_MS)
`define PBW_REPEAT_CYC      ((`PBW_CLK_HZ / 1000) * `PBW_REPEAT_MS)
`define PBW_IDLE_REV_CYC    ((`PBW_CLK_HZ / 1000) * `PBW_IDLE_REV_MS)
`define PBW_STORE_CYC       ((`PBW_CLK_HZ / 1000) * `PBW_STORE_MS)
`define PBW_DSTEP_MIN_CYC   ((`PBW_CLK_HZ / 1000000) * `PBW_DSTEP_MIN_US)

// wiper range and store policy
`define PBW_POS_MAX         6'h3f
`define PBW_POS_RESET       6'h00
`define PBW_STORE_BIT       3
`define PBW_CNT_W           28

`endif

// [logic/pbw_pkg.sv]
package pbw_pkg;

    typedef enum logic [1:0]
    {
        PBW_IDLE  = 2'b00,
        PBW_LOW   = 2'b01,
        PBW_HOLD  = 2'b10,
        PBW_GAP   = 2'b11
    } pbw_chan_st_t;

    // per-input pulse interpreter state
    typedef struct packed
    {
        pbw_chan_st_t st;
        logic [27:0]  cnt;
        logic         prev;
    } pbw_chan_t;

    // nonvolatile store request and data
    typedef struct packed
    {
        logic       req;
        logic [5:0] data;
    } pbw_nv_t;

    typedef struct packed
    {
        logic        loaded;
        logic        single;
        logic        dirUp;
        logic [5:0]  pos;
        logic [27:0] idleCnt;
        logic        firstDone;
        logic [5:0]  stored;
        logic        pending;
        logic [27:0] storeCnt;
        pbw_nv_t     nv;
    } pbw_core_t;

endpackage

// [logic/pushbutton_wiper_stepper.sv]
// Functional notes
// RULE1 - wiper is a 6-bit, 64-position value
// RULE2 - all step inputs active low
// RULE3 - falling edge starts a pulse
// RULE4 - each recognised pulse moves one position; pulses on two inputs in the same cycle move it only once
// RULE5 - driver holds single pulse 1 ms to 1 s
// RULE6 - high gaps under 1 ms merge pulses
// RULE7 - held past 1 s steps every 100 ms
// RULE8 - down input high at power-up: single-button
// RULE9 - single-button: up input moves both ways
// RULE10 - first move opposes previous direction
// RULE11 - reverse after 1 s idle or at ends
// RULE12 - digital input always active, single-button style
// RULE13 - down input floating at power-up: two-button
// RULE14 - driver uses open drain during power-up
// RULE15 - two-button: up raises, down lowers
// RULE16 - two-button: stays at end, no reversal
// RULE17 - contact inputs debounced internally
// RULE18 - power-up loads stored position
// RULE19 - store after 2 s, first change always
// RULE20 - later stores only on bit 3 change
// RULE21 - party keeps power 2 s after change
// RULE22 - worn storage still steps normally
// RULE23 - digital pulses may be 1 us short
// RULE24 - position clamps at 0 and 63
// RULE25 - all intervals counted in clock ticks
`include "pbw_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module pushbutton_wiper_stepper
    import pbw_pkg::*;
#(
    parameter int HOLD_CYC    = `PBW_HOLD_CYC,
    parameter int REPEAT_CYC  = `PBW_REPEAT_CYC,
    parameter int IDLE_CYC    = `PBW_IDLE_REV_CYC,
    parameter int STORE_CYC   = `PBW_STORE_CYC,
    parameter int MIN_CYC     = `PBW_MIN_PULSE_CYC,
    parameter int DMIN_CYC    = `PBW_DSTEP_MIN_CYC
)
(
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic       upContactInput,
    input  wire logic       downContactInput,
    input  wire logic       digitalStepInput,
    input  wire logic [5:0] nvReadData,
    input  wire logic       nvWriteDone,
    output logic [5:0]      wiperPos,
    output logic            singleButtonMode,
    output logic            nvWriteReq,
    output logic [5:0]      nvWriteData
);

    // =====================================================================
    // pulse interpreter, one per input: 0 up, 1 down, 2 digital
    // =====================================================================
    pbw_chan_t chan [3];
    pbw_chan_t next_chan [3];
    logic [2:0] stepPulse;
    logic [2:0] rawIn;
    logic       idleAll;

    assign rawIn = {digitalStepInput, downContactInput, upContactInput};

    // the qualify time doubles as the debounce: bounce shorter than it is ignored
    function automatic logic [27:0] minLow(input int idx);
        minLow = (idx == 2) ? 28'(DMIN_CYC) : 28'(MIN_CYC);
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : gChan
            // low time measured; high gaps shorter than min merge the pulse
            always_comb
            begin
                next_chan[gi]      = chan[gi];
                next_chan[gi].prev = rawIn[gi];
                stepPulse[gi]      = 1'b0;
                case (chan[gi].st)
                    PBW_IDLE:
                    begin
                        if (chan[gi].prev && !rawIn[gi]) // RULE2 RULE3
                        begin
                            next_chan[gi].st  = PBW_LOW;
                            next_chan[gi].cnt = 28'h0000000;
                        end
                    end
                    PBW_LOW:
                    begin
                        if (!rawIn[gi])
                        begin
                            next_chan[gi].cnt = chan[gi].cnt + 28'h0000001;
                            if (chan[gi].cnt + 28'h0000001 >= 28'(HOLD_CYC))
                            begin
                                // first step after the initial hold
                                stepPulse[gi]     = 1'b1; // RULE7
                                next_chan[gi].st  = PBW_HOLD;
                                next_chan[gi].cnt = 28'h0000000;
                            end
                        end
                        else
                        begin
                            next_chan[gi].st  = PBW_GAP;
                            next_chan[gi].cnt = 28'h0000000;
                        end
                    end
                    PBW_HOLD:
                    begin
                        if (rawIn[gi])
                        begin
                            // release must stay high for the qualify time too,
                            // or a bouncing release would start a fresh pulse
                            if (!chan[gi].prev)
                                next_chan[gi].cnt = 28'h0000001;
                            else if (chan[gi].cnt + 28'h0000001 >= minLow(gi))
                                next_chan[gi].st = PBW_IDLE; // RULE17
                            else
                                next_chan[gi].cnt = chan[gi].cnt + 28'h0000001;
                        end
                        else if (chan[gi].prev)
                        begin
                            // contact fell back during release: bounce, restart the repeat interval
                            next_chan[gi].cnt = 28'h0000000; // RULE17
                        end
                        else if (chan[gi].cnt + 28'h0000001 >= 28'(REPEAT_CYC))
                        begin
                            stepPulse[gi]     = 1'b1; // RULE7
                            next_chan[gi].cnt = 28'h0000000;
                        end
                        else
                            next_chan[gi].cnt = chan[gi].cnt + 28'h0000001;
                    end
                    PBW_GAP:
                    begin
                        if (!rawIn[gi])
                        begin
                            // short high time: same pulse continues
                            next_chan[gi].st = PBW_LOW; // RULE6 RULE17
                        end
                        else if (chan[gi].cnt + 28'h0000001 >= minLow(gi))
                        begin
                            // pulse over once the line stays high for the minimum: it counts whatever its low time was
                            next_chan[gi].st = PBW_IDLE;
                            if (chan[gi].prev)
                                stepPulse[gi] = 1'b1; // RULE4
                        end
                        else
                            next_chan[gi].cnt = chan[gi].cnt + 28'h0000001;
                    end
                    default:
                        next_chan[gi] = '0;
                endcase
            end

            always_ff @(posedge mclk or posedge reset)
            begin
                if (reset)
                begin
                    chan[gi].st   <= PBW_IDLE;
                    chan[gi].cnt  <= 28'h0000000;
                    // a line low at release is the mode strap, not a closure
                    chan[gi].prev <= 1'b0; // RULE3
                end
                else
                    chan[gi] <= next_chan[gi];
            end
        end
    endgenerate

    // the down channel never feeds the idle timer: only up and digital steps alternate
    assign idleAll = (chan[0].st == PBW_IDLE) && (chan[2].st == PBW_IDLE);

    // =====================================================================
    // wiper core and store policy
    // =====================================================================
    // clamped single moves; asking for a step past an end leaves the wiper there
    function automatic logic [5:0] posUp(input logic [5:0] p);
        posUp = (p == `PBW_POS_MAX) ? p : p + 6'h01; // RULE24
    endfunction

    function automatic logic [5:0] posDown(input logic [5:0] p);
        posDown = (p == 6'h00) ? p : p - 6'h01; // RULE24
    endfunction

    // true when the move about to be made reaches an end
    function automatic logic nearEnd(input logic [5:0] p, input logic up);
        nearEnd = up ? (p >= `PBW_POS_MAX - 6'h01) : (p <= 6'h01);
    endfunction

    // first change always written, later ones only when the eighth-range bit flips;
    // this keeps cell wear to one write per coarse move
    function automatic logic storeWanted(input pbw_core_t c);
        storeWanted = !c.firstDone ||
                      (c.pos[`PBW_STORE_BIT] != c.stored[`PBW_STORE_BIT]); // RULE20
    endfunction

    // loads position and mode one cycle after release, then steps
    pbw_core_t core;
    pbw_core_t next_core;
    logic      alternate;
    logic      atEnd;

    always_comb
    begin
        next_core        = core;
        next_core.nv.req = 1'b0;
        alternate        = 1'b0;
        atEnd            = 1'b0;
        if (!core.loaded)
        begin
            // strap caught one cycle after reset release
            next_core.loaded = 1'b1;
            next_core.single = downContactInput; // RULE8 RULE13
            next_core.pos    = nvReadData; // RULE18
            next_core.stored = nvReadData;
        end
        else
        begin
            // alternating-direction step from up (single mode) or digital input
            alternate = stepPulse[2] || (core.single && stepPulse[0]); // RULE9 RULE12
            if (alternate)
            begin
                next_core.idleCnt = 28'h0000000;
                // the end test looks one move ahead so the turn follows the step that hits the end
                next_core.pos = core.dirUp ? posUp(core.pos) : posDown(core.pos); // RULE24
                atEnd         = nearEnd(core.pos, core.dirUp);
                if (atEnd)
                    next_core.dirUp = !core.dirUp; // RULE11
            end
            // two buttons: an end simply clamps, direction never turns
            else if (!core.single && stepPulse[0])
                next_core.pos = posUp(core.pos); // RULE15 RULE16
            else if (!core.single && stepPulse[1])
                next_core.pos = posDown(core.pos); // RULE15 RULE16
            // idle timer: after a long quiet spell next move reverses
            if (!alternate && idleAll)
            begin
                if (core.idleCnt + 28'h0000001 == 28'(IDLE_CYC))
                    next_core.dirUp = !core.dirUp; // RULE10 RULE11
                if (core.idleCnt != 28'(IDLE_CYC))
                    next_core.idleCnt = core.idleCnt + 28'h0000001; // RULE25
            end
            else if (!idleAll)
                next_core.idleCnt = 28'h0000000;
            // any change restarts the 2 s settle delay
            if (next_core.pos != core.pos)
            begin
                next_core.pending  = 1'b1;
                next_core.storeCnt = 28'h0000000;
            end
            else if (core.pending)
            begin
                if (core.storeCnt + 28'h0000001 >= 28'(STORE_CYC))
                begin
                    next_core.pending = 1'b0;
                    if (storeWanted(core)) // RULE19 RULE20
                    begin
                        next_core.nv.req    = 1'b1;
                        next_core.nv.data   = core.pos;
                        next_core.firstDone = 1'b1;
                        next_core.stored    = core.pos;
                    end
                end
                else
                    next_core.storeCnt = core.storeCnt + 28'h0000001;
            end
        end
    end

    // a worn cell simply never takes the write; stepping is unaffected
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            // empty store history; wiper parked at zero until the load
            core.loaded    <= 1'b0;
            core.single    <= 1'b0;
            core.dirUp     <= 1'b0; // direction starts downward
            core.pos       <= `PBW_POS_RESET; // RULE22
            core.idleCnt   <= 28'h0000000;
            core.firstDone <= 1'b0;
            core.stored    <= `PBW_POS_RESET;
            core.pending   <= 1'b0;
            core.storeCnt  <= 28'h0000000;
            core.nv        <= '0;
        end
        else
            core <= next_core;
    end

    // =====================================================================
    // outputs
    // =====================================================================
    // straight from the state register, no logic after the flops
    assign wiperPos         = core.pos; // RULE1
    assign singleButtonMode = core.single;
    assign nvWriteReq       = core.nv.req;
    assign nvWriteData      = core.nv.data;

endmodule

`default_nettype wire

// [tb/pbw_button_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// pushbutton or processor driving the steps
module pbw_button_model
(
    input  wire logic mclk,
    output logic      upContactInput,
    output logic      downContactInput,
    output logic      digitalStepInput
);
    // lines idle high like the pull-ups; bit 1 also acts as power-up strap
    logic [2:0] lineN = 3'h7;

    assign {digitalStepInput, downContactInput, upContactInput} = lineN;

    // one closure, then a high gap; short gaps are the merge case
    task automatic press(input int ch, input int lowCyc, input int gapCyc);
        @(posedge mclk);
        lineN[ch] <= 1'b0;
        repeat (lowCyc) @(posedge mclk);
        lineN[ch] <= 1'b1;
        repeat (gapCyc) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// [tb/pbw_step_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// step and store monitor
module pbw_step_monitor
#(
    parameter int STORE_CYC = 200,
    parameter int MIN_CYC   = 5
)
(
    input wire logic       mclk,
    input wire logic       reset,
    input wire logic       upContactInput,
    input wire logic       downContactInput,
    input wire logic       digitalStepInput,
    input wire logic [5:0] wiperPos,
    input wire logic       singleButtonMode,
    input wire logic       nvWriteReq,
    input wire logic [5:0] nvWriteData
);
    logic [1:0]  live;
    logic [5:0]  prevPos;
    logic [31:0] still;
    logic [31:0] upQ;
    logic [31:0] dnQ;
    logic [31:0] digQ;
    wire         settled = (live == 2'h3);
    wire         dnUsed = !singleButtonMode;
    wire         near = (upQ <= MIN_CYC + 3) || (digQ <= MIN_CYC + 3);
    wire         nearDn = (dnUsed && dnQ <= MIN_CYC + 3) || (digQ <= MIN_CYC + 3);

    // idle counters; the first cycles after release carry the power-up load
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            live    <= 2'h0;
            prevPos <= 6'h00;
            still   <= '0;
            upQ     <= '0;
            dnQ     <= '0;
            digQ    <= '0;
        end
        else
        begin
            live    <= settled ? live : live + 2'h1;
            prevPos <= wiperPos;
            still   <= (wiperPos != prevPos) ? '0 : still + 1;
            upQ     <= upContactInput ? upQ + 1 : '0;
            dnQ     <= downContactInput ? dnQ + 1 : '0;
            digQ    <= digitalStepInput ? digQ + 1 : '0;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    a_pos_unit_step: assert property (settled && !$stable(wiperPos) |->
        ({1'b0, wiperPos} + 7'h01 == {1'b0, $past(wiperPos)}) ||
        ({1'b0, $past(wiperPos)} + 7'h01 == {1'b0, wiperPos})) else $error("wiper jumped");
    a_write_one_cycle: assert property (nvWriteReq |=> !nvWriteReq) else $error("long write");
    a_write_data_pos: assert property (nvWriteReq |-> nvWriteData == wiperPos)
        else $error("store data wrong");
    a_store_wait_time: assert property (nvWriteReq |-> still >= STORE_CYC - 2)
        else $error("store too early");
    a_mode_held: assert property (settled |-> $stable(singleButtonMode)) else $error("mode moved");
    a_no_drift: assert property (settled && !near && !nearDn |-> $stable(wiperPos))
        else $error("move without input");
    a_up_raises: assert property (settled && dnUsed && wiperPos > $past(wiperPos) |-> near)
        else $error("rise without up");
    a_down_lowers: assert property (settled && dnUsed && wiperPos < $past(wiperPos) |-> nearDn)
        else $error("fall without down");

    c_write: cover property (nvWriteReq);
    c_single_step: cover property (settled && singleButtonMode && !$stable(wiperPos));
    c_bottom: cover property (settled && wiperPos == 6'h00);
endmodule
`default_nettype wire

// [tb/pushbutton_wiper_stepper_test.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// wiper stepper bench
module pushbutton_wiper_stepper_test;
    localparam int HOLD = 100;
    localparam int REP = 20;
    localparam int IDLE = 100;
    localparam int STORE = 200;
    logic       mclk;
    logic       reset = 1'b1;
    logic       upC;
    logic       dnC;
    logic       digC;
    logic [5:0] nvReadData = 6'h00;
    logic [5:0] wiperPos;
    logic [5:0] nvWriteData;
    logic [5:0] lastData;
    logic [5:0] base;
    logic [5:0] d;
    logic       singleButtonMode;
    logic       nvWriteReq;
    int         failures = 0;
    int         num_checks = 0;
    int         writes = 0;

    pbw_button_model u_pbw_button_model (.mclk(mclk), .upContactInput(upC),
        .downContactInput(dnC), .digitalStepInput(digC));

    // short counts keep the run small; the nonvolatile answer is unused
    pushbutton_wiper_stepper #(.HOLD_CYC(HOLD), .REPEAT_CYC(REP), .IDLE_CYC(IDLE),
        .STORE_CYC(STORE), .MIN_CYC(5), .DMIN_CYC(2)) u_pushbutton_wiper_stepper (
        .mclk(mclk), .reset(reset), .upContactInput(upC), .downContactInput(dnC),
        .digitalStepInput(digC), .nvReadData(nvReadData), .nvWriteDone(1'b0),
        .wiperPos(wiperPos), .singleButtonMode(singleButtonMode),
        .nvWriteReq(nvWriteReq), .nvWriteData(nvWriteData));

    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // store requests seen since the last power-up
    always @(posedge mclk)
    begin
        if (nvWriteReq === 1'b1)
        begin
            writes <= writes + 1;
            lastData <= nvWriteData;
        end
    end

    task automatic check(input logic [5:0] seen, input logic [5:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask

    task automatic press(input int ch, input int lowCyc, input int gapCyc);
        u_pbw_button_model.press(ch, lowCyc, gapCyc);
    endtask

    // strap is released like an open drain once the mode is latched
    task automatic power_up(input logic strapV, input logic [5:0] nv);
        @(posedge mclk);
        reset <= 1'b1;
        nvReadData <= nv;
        u_pbw_button_model.lineN[1] <= strapV;
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        repeat (3) @(posedge mclk);
        u_pbw_button_model.lineN[1] <= 1'b1;
        writes <= 0;
        repeat (10) @(posedge mclk);
    endtask

    task automatic t_two_button;
        power_up(1'b0, 6'h05);
        check({5'h0, singleButtonMode}, 6'h00);
        check(wiperPos, 6'h05);
        press(0, 10, 20);
        check(wiperPos, 6'h06);
        press(1, 10, 20);
        check(wiperPos, 6'h05);
        press(0, 10, 2);
        press(0, 10, 20);
        check(wiperPos, 6'h06);
    endtask

    task automatic t_store;
        repeat (STORE + 10) @(posedge mclk);
        check(writes[5:0], 6'h01);
        check(lastData, 6'h06);
        press(0, 10, 20);
        repeat (STORE + 10) @(posedge mclk);
        check(writes[5:0], 6'h01);
        press(0, 10, 20);
        repeat (STORE + 10) @(posedge mclk);
        check(writes[5:0], 6'h02);
        check(lastData, 6'h08);
    endtask

    task automatic t_hold;
        // release bounces once: the short low after it must not add a step
        press(1, HOLD + 3 * REP + 5, 1);
        press(1, 2, 20);
        check(wiperPos, 6'h04);
        press(1, HOLD + 8 * REP, 20);
        check(wiperPos, 6'h00);
        press(0, 10, 20);
        check(wiperPos, 6'h01);
    endtask

    // direction is unknown at first, so later moves are judged against it
    task automatic t_single;
        power_up(1'b1, 6'h20);
        check({5'h0, singleButtonMode}, 6'h01);
        base = wiperPos;
        press(2, 3, 10);
        d = wiperPos - base;
        check({5'h0, (d == 6'h01) || (d == 6'h3f)}, 6'h01);
        press(0, 10, 20);
        check(wiperPos, base + d + d);
        press(1, 10, 20);
        check(wiperPos, base + d + d);
        repeat (IDLE + 10) @(posedge mclk);
        press(0, 10, 20);
        check(wiperPos, base + d);
    endtask

    task automatic complete_run;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        t_two_button();
        t_store();
        t_hold();
        t_single();
        complete_run();
    end

    // about 1600 cycles expected
    initial
    begin
        #200us;
        failures++;
        complete_run();
    end
endmodule

bind pushbutton_wiper_stepper pbw_step_monitor #(.STORE_CYC(STORE_CYC), .MIN_CYC(MIN_CYC)) u_pbw_step_monitor (
    .mclk(mclk), .reset(reset), .upContactInput(upContactInput),
    .downContactInput(downContactInput), .digitalStepInput(digitalStepInput),
    .wiperPos(wiperPos), .singleButtonMode(singleButtonMode),
    .nvWriteReq(nvWriteReq), .nvWriteData(nvWriteData));
`default_nettype wire
